// file: core/apl_client.sv
`timescale 1ns/1ns
`include "apl_map.svh"
module apl_client
    import apl_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst_n,
    apl_link_if.client      link,
    // user asks for a session: command+data characters streamed after start
    input  wire logic       start,
    input  wire logic       isRead,
    input  wire logic [7:0] bodyLen,
    input  wire logic [7:0] bodyByte,
    output logic            bodyReq,
    output logic            busy,
    output logic            doneOk,
    output logic            doneFail,
    output logic            rxValid,
    output logic [7:0]      rxByte
);
    apl_cli_state_t stateFf;
    logic [8:0]     idxFf;
    logic [7:0]     csumFf;
    logic [7:0]     lenFf;
    logic           readFf;
    logic [3:0]     rspCntFf;
    logic           rspOkFf;
    logic [7:0]     txB;
    logic           txGo;
    function automatic logic [7:0] hexChar(input logic [3:0] n);
        hexChar = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
    endfunction
    // outgoing byte per state and index
    always_comb begin
        txB  = `APL_ENQ;
        txGo = stateFf == APL_CLI_SEND_ENQ || stateFf == APL_CLI_SEND_PKT
               || stateFf == APL_CLI_SEND_DACK || stateFf == APL_CLI_SEND_EOT;
        if (stateFf == APL_CLI_SEND_DACK) txB = `APL_ACK;
        else if (stateFf == APL_CLI_SEND_EOT) txB = `APL_EOT;
        else if (stateFf == APL_CLI_SEND_PKT) begin
            if (idxFf == 9'd0) txB = `APL_STX;
            else if (idxFf == 9'd1) txB = hexChar(lenFf[7:4]);
            else if (idxFf == 9'd2) txB = hexChar(lenFf[3:0]);
            else if (idxFf < {1'b0, lenFf} + 9'd3) txB = bodyByte;
            else if (idxFf == {1'b0, lenFf} + 9'd3) txB = hexChar(csumFf[7:4]);
            else if (idxFf == {1'b0, lenFf} + 9'd4) txB = hexChar(csumFf[3:0]);
            else txB = `APL_ETX;
        end
    end
    assign link.c2dValid = txGo;
    assign link.c2dData  = txB;
    assign link.d2cReady = 1'b1;
    assign bodyReq       = stateFf == APL_CLI_SEND_PKT && link.c2dReady && idxFf >= 9'd3
                           && idxFf < {1'b0, lenFf} + 9'd3;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stateFf  <= APL_CLI_IDLE;
            idxFf    <= 9'd0;
            csumFf   <= `APL_CSUM_SEED;
            lenFf    <= 8'h00;
            readFf   <= 1'b0;
            rspCntFf <= 4'd0;
            rspOkFf  <= 1'b0;
            busy     <= 1'b0;
            doneOk   <= 1'b0;
            doneFail <= 1'b0;
            rxValid  <= 1'b0;
            rxByte   <= 8'h00;
        end else begin
            doneOk   <= 1'b0;
            doneFail <= 1'b0;
            rxValid  <= 1'b0;
            unique case (stateFf)
                APL_CLI_IDLE: if (start) begin
                    lenFf   <= bodyLen;
                    readFf  <= isRead;
                    busy    <= 1'b1;
                    stateFf <= APL_CLI_SEND_ENQ;
                end
                APL_CLI_SEND_ENQ: if (link.c2dReady) stateFf <= APL_CLI_WAIT_ACK;
                APL_CLI_WAIT_ACK: if (link.d2cValid && link.d2cData == `APL_ACK) begin
                    idxFf   <= 9'd0;
                    csumFf  <= `APL_CSUM_SEED;
                    stateFf <= APL_CLI_SEND_PKT;
                end
                APL_CLI_SEND_PKT: if (link.c2dReady) begin
                    idxFf <= idxFf + 9'd1;
                    if (idxFf >= 9'd1 && idxFf < {1'b0, lenFf} + 9'd3) csumFf <= csumFf - txB;
                    if (idxFf == {1'b0, lenFf} + 9'd5) begin
                        rspCntFf <= 4'd0;
                        stateFf  <= APL_CLI_WAIT_RSP;
                    end
                end
                APL_CLI_WAIT_RSP: if (link.d2cValid) begin
                    rspCntFf <= rspCntFf + 4'd1;
                    if (rspCntFf == 4'd4) rspOkFf <= link.d2cData == `APL_OK_CODE_LO;
                    if (link.d2cData == `APL_ETX) begin
                        if (!rspOkFf) begin
                            doneFail <= 1'b1;
                            stateFf  <= APL_CLI_SEND_EOT;
                        end else if (readFf) stateFf <= APL_CLI_SEND_DACK;
                        else stateFf <= APL_CLI_SEND_EOT;
                    end
                end
                APL_CLI_SEND_DACK: if (link.c2dReady) stateFf <= APL_CLI_WAIT_DATA;
                APL_CLI_WAIT_DATA: if (link.d2cValid) begin
                    rxValid <= 1'b1;
                    rxByte  <= link.d2cData;
                    if (link.d2cData == `APL_ETX) stateFf <= APL_CLI_SEND_EOT;
                end
                APL_CLI_SEND_EOT: if (link.c2dReady) begin
                    doneOk  <= rspOkFf;
                    busy    <= 1'b0;
                    stateFf <= APL_CLI_IDLE;
                end
                default: stateFf <= APL_CLI_IDLE;
            endcase
        end
    end
endmodule

// file: core/apl_device.sv
`timescale 1ns/1ns
`include "apl_map.svh"
// Overview of operation
// - checksum is zero minus bytes, low byte; device data packets send 00 instead
// - checksum covers length, command and data; device data packets send a fixed 00 covering nothing
// - checksum sent as two hex characters
// - bad checksum answered with failure packet
// - packets end with end-of-text byte
// - control bytes travel bare, no framing
// - client opens session with enquiry
// - enquiry answered by acknowledge, then wait
// - client sends packet within two seconds
// - silence past timeout gives failure packet
// - executed write answered with success packet
// - malformed or unexecuted packet gets failure
// - after failure client retries or ends; apl_client always ends with EOT and the device has already returned to idle
// - read accepted: success packet comes first
// - only reads return data to client
// - packets begin with start-of-text byte
// - length is two hex characters
// - command four chars, data up to 251
// - data packet follows client acknowledge
module apl_device
    import apl_pkg::*;
#(
    parameter int TIMEOUT_CYC = `APL_TIMEOUT_CYC,
    parameter int FIFO_DEPTH  = 8
) (
    input  wire logic clock,
    input  wire logic rst_n,
    apl_link_if.device link,
    // received packet handed to the user, command and data characters only
    output logic       pktByteValid,
    output logic [7:0] pktByte,
    output logic       pktLast,
    // user verdict on the packet, one-cycle pulses
    input  wire logic  execOk,
    input  wire logic  execFail,
    input  wire logic  execIsRead,
    // read data packet characters from the user, framed by this block
    input  wire logic       rdValid,
    input  wire logic [7:0] rdByte,
    input  wire logic       rdLast,
    output logic            rdReady,
    output logic            sessionOpen
);
    initial begin
        if (TIMEOUT_CYC < 1) $error("apl_device: TIMEOUT_CYC must be positive");
    end
    apl_dev_state_t stateFf;
    logic [31:0]    timerFf;
    logic [3:0]     phaseFf;
    logic [7:0]     csumFf;
    logic [8:0]     lenFf;
    logic [8:0]     cntFf;
    logic [7:0]     rxHiFf;
    logic           okFf;
    logic           readFf;
    logic           badFf;
    logic           waitVerdictFf;
    logic           txValid;
    logic [7:0]     txByte;
    logic           txReady;
    logic           rxTake;
    logic [7:0]     rxB;
    logic [3:0]     nib;
    logic           isHex;
    logic [7:0]     dataCsumFf;
    logic [7:0]     dataLenFf;
    logic           dataDoneFf;
    // ascii hex decode of the incoming byte
    always_comb begin
        nib   = 4'h0;
        isHex = 1'b1;
        if (rxB >= 8'h30 && rxB <= 8'h39) nib = 4'(rxB - 8'h30);
        else if (rxB >= 8'h41 && rxB <= 8'h46) nib = 4'(rxB - 8'h37);
        else if (rxB >= 8'h61 && rxB <= 8'h66) nib = 4'(rxB - 8'h57);
        else isHex = 1'b0;
    end
    function automatic logic [7:0] hexChar(input logic [3:0] n);
        hexChar = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
    endfunction
    assign rxB          = link.c2dData;
    assign link.c2dReady = (stateFf == APL_DEV_IDLE) || (stateFf == APL_DEV_WAIT_PKT)
                         || (stateFf == APL_DEV_RX_PKT && !waitVerdictFf) || (stateFf == APL_DEV_WAIT_DACK);
    assign rxTake       = link.c2dValid && link.c2dReady;
    // outbound bytes pass the fifo so a slow client stalls the framer
    apl_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) txFifo (
        .clock    (clock),
        .rst_n    (rst_n),
        .inValid  (txValid),
        .inReady  (txReady),
        .inData   (txByte),
        .outValid (link.d2cValid),
        .outReady (link.d2cReady),
        .outData  (link.d2cData)
    );
    // transmit byte generator for ack, responses and data packets
    always_comb begin
        txValid = 1'b0;
        txByte  = `APL_STX;
        rdReady = 1'b0;
        unique case (stateFf)
            APL_DEV_SEND_ACK: begin
                txValid = 1'b1;
                txByte  = `APL_ACK;
            end
            APL_DEV_SEND_RSP: begin
                txValid = 1'b1;
                unique case (phaseFf)
                    4'd0: txByte = `APL_STX;
                    4'd1: txByte = `APL_RSP_LEN_HI;
                    4'd2: txByte = `APL_RSP_LEN_LO;
                    4'd3: txByte = `APL_RSP_CODE_HI;
                    4'd4: txByte = okFf ? `APL_OK_CODE_LO : `APL_FAIL_CODE_LO;
                    4'd5: txByte = okFf ? `APL_OK_CSUM_HI : `APL_FAIL_CSUM_HI;
                    4'd6: txByte = okFf ? `APL_OK_CSUM_LO : `APL_FAIL_CSUM_LO;
                    default: txByte = `APL_ETX;
                endcase
            end
            APL_DEV_SEND_DATA: begin
                // data packet: stx, length, payload, checksum, etx
                txValid = 1'b1;
                unique case (phaseFf)
                    4'd0: txByte = `APL_STX;
                    4'd1: txByte = hexChar(dataLenFf[7:4]);
                    4'd2: txByte = hexChar(dataLenFf[3:0]);
                    4'd3: begin
                        txValid = rdValid;
                        txByte  = rdByte;
                        rdReady = txReady;
                    end
                    4'd4: txByte = hexChar(dataCsumFf[7:4]);
                    4'd5: txByte = hexChar(dataCsumFf[3:0]);
                    default: txByte = `APL_ETX;
                endcase
            end
            default: ;
        endcase
    end
    // session sequencer
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stateFf       <= APL_DEV_IDLE;
            phaseFf       <= 4'd0;
            okFf          <= 1'b0;
            readFf        <= 1'b0;
            waitVerdictFf <= 1'b0;
            dataDoneFf    <= 1'b0;
        end else begin
            unique case (stateFf)
                APL_DEV_IDLE: if (rxTake && rxB == `APL_ENQ) stateFf <= APL_DEV_SEND_ACK;
                APL_DEV_SEND_ACK: if (txReady) stateFf <= APL_DEV_WAIT_PKT;
                APL_DEV_WAIT_PKT: begin
                    if (rxTake && rxB == `APL_EOT) stateFf <= APL_DEV_IDLE;
                    else if (rxTake && rxB == `APL_STX) stateFf <= APL_DEV_RX_PKT;
                    else if (timerFf == 32'd0) begin
                        okFf    <= 1'b0;
                        phaseFf <= 4'd0;
                        stateFf <= APL_DEV_SEND_RSP;
                    end
                end
                APL_DEV_RX_PKT: begin
                    if (waitVerdictFf) begin
                        if (execOk || execFail) begin
                            waitVerdictFf <= 1'b0;
                            okFf          <= execOk && !execFail;
                            readFf        <= execOk && !execFail && execIsRead;
                            phaseFf       <= 4'd0;
                            stateFf       <= APL_DEV_SEND_RSP;
                        end
                    end else if (rxTake && rxB == `APL_ETX) begin
                        phaseFf <= 4'd0;
                        if (badFf || cntFf != lenFf + 9'd4 || rxHiFf != csumFf) begin
                            okFf    <= 1'b0;
                            stateFf <= APL_DEV_SEND_RSP;
                        end else begin
                            waitVerdictFf <= 1'b1;
                        end
                    end else if (timerFf == 32'd0) begin
                        okFf    <= 1'b0;
                        phaseFf <= 4'd0;
                        stateFf <= APL_DEV_SEND_RSP;
                    end
                end
                APL_DEV_SEND_RSP: if (txReady) begin
                    phaseFf <= phaseFf + 4'd1;
                    if (phaseFf == 4'd7) begin
                        // failure drops the session to idle; any retry needs a fresh enquiry
                        stateFf <= !okFf ? APL_DEV_IDLE : (readFf ? APL_DEV_WAIT_DACK : APL_DEV_WAIT_PKT);
                    end
                end
                APL_DEV_WAIT_DACK: begin
                    if (rxTake && rxB == `APL_ACK) begin
                        phaseFf    <= 4'd0;
                        dataDoneFf <= 1'b0;
                        stateFf    <= APL_DEV_SEND_DATA;
                    end else if (rxTake && rxB == `APL_EOT) stateFf <= APL_DEV_IDLE;
                end
                APL_DEV_SEND_DATA: begin
                    if (phaseFf == 4'd3) begin
                        if (rdValid && txReady && rdLast) phaseFf <= 4'd4;
                    end else if (txReady) begin
                        phaseFf <= phaseFf + 4'd1;
                        if (phaseFf == 4'd6) begin
                            readFf  <= 1'b0;
                            stateFf <= APL_DEV_WAIT_PKT;
                        end
                    end
                end
                default: stateFf <= APL_DEV_IDLE;
            endcase
        end
    end
    // inbound packet parser: length, checksum, character count
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            csumFf <= `APL_CSUM_SEED;
            lenFf  <= 9'd0;
            cntFf  <= 9'd0;
            rxHiFf <= 8'h00;
            badFf  <= 1'b0;
        end else if (stateFf != APL_DEV_RX_PKT) begin
            csumFf <= `APL_CSUM_SEED;
            cntFf  <= 9'd0;
            badFf  <= 1'b0;
        end else if (rxTake && rxB != `APL_ETX) begin
            cntFf <= cntFf + 9'd1;
            if (cntFf < 9'd2) begin
                lenFf <= {1'b0, lenFf[3:0], nib};
                if (!isHex) badFf <= 1'b1;
            end
            // last two chars are the checksum, held back from the sum
            if (cntFf >= 9'd2 && cntFf >= lenFf + 9'd2) begin
                rxHiFf <= {rxHiFf[3:0], nib};
                if (!isHex) badFf <= 1'b1;
            end else begin
                csumFf <= csumFf - rxB;
            end
            if (cntFf == 9'd2 + 9'd4 + 9'(`APL_MAX_DATA) + 9'd2) badFf <= 1'b1;
            if (cntFf == 9'd1 && lenFf[3:0] == 4'h0 && nib < 4'(`APL_CMD_CHARS)) badFf <= 1'b1;
        end
    end
    // user handoff of command and data characters
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pktByteValid <= 1'b0;
            pktByte      <= 8'h00;
            pktLast      <= 1'b0;
            sessionOpen  <= 1'b0;
        end else begin
            pktByteValid <= stateFf == APL_DEV_RX_PKT && rxTake && rxB != `APL_ETX
                            && cntFf >= 9'd2 && cntFf < lenFf + 9'd2;
            pktByte      <= rxB;
            pktLast      <= cntFf + 9'd1 == lenFf + 9'd2;
            sessionOpen  <= stateFf != APL_DEV_IDLE;
        end
    end
    // timeout restarts on any received character
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            timerFf <= 32'(TIMEOUT_CYC);
        end else if (rxTake || !(stateFf == APL_DEV_WAIT_PKT || stateFf == APL_DEV_RX_PKT) || waitVerdictFf) begin
            timerFf <= 32'(TIMEOUT_CYC);
        end else if (timerFf != 32'd0) begin
            timerFf <= timerFf - 32'd1;
        end
    end
    // read data length and checksum are never collected; both stay zero, cleared while waiting for the data acknowledge
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dataCsumFf <= `APL_CSUM_SEED;
            dataLenFf  <= 8'h00;
        end else if (stateFf == APL_DEV_WAIT_DACK) begin
            dataCsumFf <= `APL_CSUM_SEED;
            dataLenFf  <= 8'h00;
        end
    end
endmodule

// file: core/apl_fifo.sv
`timescale 1ns/1ns
module apl_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) $error("apl_fifo: DEPTH must be a power of two >= 2");
    end
    logic [WIDTH-1:0] memFf [DEPTH];
    logic [AW:0]      wrPtrFf;
    logic [AW:0]      rdPtrFf;
    logic             doWr;
    logic             doRd;
    // full when pointers differ only in the wrap bit
    assign inReady  = !((wrPtrFf[AW] != rdPtrFf[AW]) && (wrPtrFf[AW-1:0] == rdPtrFf[AW-1:0]));
    assign outValid = wrPtrFf != rdPtrFf;
    assign outData  = memFf[rdPtrFf[AW-1:0]];
    assign doWr     = inValid && inReady;
    assign doRd     = outValid && outReady;
    // storage has no reset; only pointers matter
    always_ff @(posedge clock) begin
        if (doWr) begin
            memFf[wrPtrFf[AW-1:0]] <= inData;
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wrPtrFf <= '0;
            rdPtrFf <= '0;
        end else begin
            if (doWr) begin
                wrPtrFf <= wrPtrFf + 1'b1;
            end
            if (doRd) begin
                rdPtrFf <= rdPtrFf + 1'b1;
            end
        end
    end
endmodule

// file: core/apl_link_if.sv
`timescale 1ns/1ns
// byte-level half-duplex link; each direction is a valid/ready byte stream
interface apl_link_if;
    logic       c2dValid;
    logic       c2dReady;
    logic [7:0] c2dData;
    logic       d2cValid;
    logic       d2cReady;
    logic [7:0] d2cData;
    modport device (
        input  c2dValid,
        output c2dReady,
        input  c2dData,
        output d2cValid,
        input  d2cReady,
        output d2cData
    );
    modport client (
        output c2dValid,
        input  c2dReady,
        output c2dData,
        input  d2cValid,
        output d2cReady,
        input  d2cData
    );
endinterface

// file: core/apl_map.svh
`ifndef APL_MAP_SVH
`define APL_MAP_SVH
// control bytes on the link
`define APL_STX          8'h02
`define APL_ETX          8'h03
`define APL_EOT          8'h04
`define APL_ENQ          8'h05
`define APL_ACK          8'h06
`define APL_NAK          8'h15
`define APL_SPACE        8'h20
// checksum seed
`define APL_CSUM_SEED    8'h00
// response packet characters
`define APL_RSP_LEN_HI   8'h30
`define APL_RSP_LEN_LO   8'h32
`define APL_RSP_CODE_HI  8'h41
`define APL_OK_CODE_LO   8'h30
`define APL_FAIL_CODE_LO 8'h32
`define APL_OK_CSUM_HI   8'h32
`define APL_OK_CSUM_LO   8'h44
`define APL_FAIL_CSUM_HI 8'h32
`define APL_FAIL_CSUM_LO 8'h42
// field sizes
`define APL_CMD_CHARS    4
`define APL_MAX_DATA     251
// session timeout
`define APL_TIMEOUT_MS   2000
`define APL_CLK_MHZ      125
`define APL_TIMEOUT_CYC  (`APL_TIMEOUT_MS * 1000 * `APL_CLK_MHZ)
`endif

// file: core/apl_pkg.sv
package apl_pkg;
    typedef enum {
        APL_DEV_IDLE,
        APL_DEV_SEND_ACK,
        APL_DEV_WAIT_PKT,
        APL_DEV_RX_PKT,
        APL_DEV_SEND_RSP,
        APL_DEV_WAIT_DACK,
        APL_DEV_SEND_DATA
    } apl_dev_state_t;
    typedef enum {
        APL_CLI_IDLE,
        APL_CLI_SEND_ENQ,
        APL_CLI_WAIT_ACK,
        APL_CLI_SEND_PKT,
        APL_CLI_WAIT_RSP,
        APL_CLI_SEND_DACK,
        APL_CLI_WAIT_DATA,
        APL_CLI_SEND_EOT
    } apl_cli_state_t;
endpackage

// file: test/apl_link_chk.sv
`timescale 1ns/1ns
`include "apl_map.svh"
module apl_link_chk (
    input wire logic       clock,
    input wire logic       rst_n,
    input wire logic       c2dValid,
    input wire logic       c2dReady,
    input wire logic [7:0] c2dData,
    input wire logic       d2cValid,
    input wire logic       d2cReady,
    input wire logic [7:0] d2cData
);
    logic [55:0] hist_ff;
    logic        c2dFire;
    logic        d2cFire;
    logic        etxFire;
    assign c2dFire = c2dValid && c2dReady;
    assign d2cFire = d2cValid && d2cReady;
    assign etxFire = d2cFire && d2cData == `APL_ETX;
    // last seven device bytes, so a whole response is judged at its end byte
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hist_ff <= 56'h0;
        end else if (d2cFire) begin
            hist_ff <= {hist_ff[47:0], d2cData};
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    AST_ENQ_ACK: assert property (c2dFire && c2dData == `APL_ENQ |-> ##[1:4] d2cValid && d2cData == `APL_ACK)
        else $error("enquiry not acknowledged");
    AST_C2D_HOLD: assert property (c2dValid && !c2dReady |=> c2dValid && $stable(c2dData))
        else $error("client byte dropped before taken");
    AST_D2C_HOLD: assert property (d2cValid && !d2cReady |=> d2cValid && $stable(d2cData))
        else $error("device byte dropped before taken");
    AST_CLI_STX: assert property (d2cFire && d2cData == `APL_ACK |-> ##[1:8] c2dValid && c2dData == `APL_STX)
        else $error("no packet start after acknowledge");
    AST_OK_CSUM: assert property (etxFire && hist_ff[55:16] == 40'h0230324130 |-> hist_ff[15:0] == 16'h3244)
        else $error("success packet checksum wrong");
    AST_FAIL_CSUM: assert property (etxFire && hist_ff[55:16] == 40'h0230324132 |-> hist_ff[15:0] == 16'h3242)
        else $error("failure packet checksum wrong");
    AST_RSP_LEN: assert property (etxFire && hist_ff[31:24] == 8'h41 && hist_ff[55:48] == 8'h02 |-> hist_ff[47:32] == 16'h3032)
        else $error("response length field wrong");
    AST_RSP_START: assert property (etxFire && hist_ff[31:24] == 8'h41 |-> hist_ff[55:48] == `APL_STX)
        else $error("response not opened by start byte");
endmodule

// file: test/testbench.sv
`timescale 1ns/1ns
`include "apl_map.svh"
module testbench;
    logic       clock, rst_n, start, isRead, execOk, execFail, execIsRead, rdValid, rdLast;
    logic [7:0] bodyLen, rdByte, pktByte, rxByte, bodyIdx, b;
    logic       pktByteValid, pktLast, rdReady, sessionOpen, bodyReq, busy, doneOk, doneFail, rxValid;
    logic       etxSeen, doneAny, idle;
    logic [7:0] body [0:15];
    logic [7:0] pktQ [$];
    logic [7:0] rxQ [$];
    logic       resQ [$];
    int         errorCnt, nTests, seed, k;
    apl_link_if link();
    assign etxSeen = link.c2dValid && link.c2dReady && link.c2dData == `APL_ETX;
    assign doneAny = doneOk || doneFail;
    assign idle    = !busy;
    apl_device #(.TIMEOUT_CYC(200), .FIFO_DEPTH(8)) apl_device_i (.clock(clock), .rst_n(rst_n), .link(link),
        .pktByteValid(pktByteValid), .pktByte(pktByte), .pktLast(pktLast), .execOk(execOk), .execFail(execFail),
        .execIsRead(execIsRead), .rdValid(rdValid), .rdByte(rdByte), .rdLast(rdLast), .rdReady(rdReady),
        .sessionOpen(sessionOpen));
    apl_client apl_client_i (.clock(clock), .rst_n(rst_n), .link(link), .start(start), .isRead(isRead),
        .bodyLen(bodyLen), .bodyByte(body[bodyIdx[3:0]]), .bodyReq(bodyReq), .busy(busy), .doneOk(doneOk),
        .doneFail(doneFail), .rxValid(rxValid), .rxByte(rxByte));
    apl_link_chk apl_link_chk_i (.clock(clock), .rst_n(rst_n), .c2dValid(link.c2dValid), .c2dReady(link.c2dReady),
        .c2dData(link.c2dData), .d2cValid(link.d2cValid), .d2cReady(link.d2cReady), .d2cData(link.d2cData));
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        nTests++;
        if (got !== exp) begin
            errorCnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic giveVerdict();
        $display("checks %0d errors %0d", nTests, errorCnt);
        if (errorCnt == 0 && nTests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // bounded wait; always moves past the current edge first
    task automatic waitHi(ref logic s);
        for (int i = 0; i < 3000; i++) begin
            @(posedge clock);
            if (s === 1'b1) return;
        end
        check("wait", 8'h01, 8'h00);
        giveVerdict();
    endtask
    // results pop the oldest note; a surplus byte meets an unknown and fails
    always @(posedge clock) begin
        if (pktByteValid) check("pktByte", pktQ.size() ? pktQ.pop_front() : 8'hXX, pktByte);
        if (pktByteValid) check("pktLast", {7'h00, pktQ.size() == 0}, {7'h00, pktLast});
        if (rxValid) check("rxByte", rxQ.size() ? rxQ.pop_front() : 8'hXX, rxByte);
        if (doneAny) check("doneOk", {7'h00, resQ.size() ? resQ.pop_front() : 1'bx}, {7'h00, doneOk});
    end
    always @(posedge clock) if (bodyReq) bodyIdx <= bodyIdx + 8'h01;
    task automatic session(input logic rd, input logic ok, input int n, input int rn);
        for (int i = 0; i < n; i++) begin
            body[i] = i < 2 ? 8'(8'h41 + {$random(seed)} % 26) : 8'(8'h30 + {$random(seed)} % 10);
            if (i == 2 || i == 3) body[i] = `APL_SPACE; // short command padded with spaces
            pktQ.push_back(body[i]);
        end
        resQ.push_back(ok);
        @(posedge clock);
        bodyIdx <= 8'h00;
        start <= 1'b1;
        isRead <= rd;
        bodyLen <= 8'(n);
        @(posedge clock);
        start <= 1'b0;
        waitHi(etxSeen);
        execOk <= ok;
        execFail <= !ok;
        execIsRead <= rd;
        @(posedge clock);
        {execOk, execFail, execIsRead} <= 3'h0;
        // data packet framing around the payload: start byte, then length and checksum sent as zeros
        if (rn > 0) begin
            rxQ.push_back(`APL_STX);
            rxQ.push_back(8'h30);
            rxQ.push_back(8'h30);
        end
        // payload held until the device takes it
        for (int i = 0; i < rn; i++) begin
            b = 8'(8'h30 + {$random(seed)} % 10);
            rxQ.push_back(b);
            rdValid <= 1'b1;
            rdByte <= b;
            rdLast <= (i == rn - 1);
            waitHi(rdReady);
        end
        if (rn > 0) begin
            rxQ.push_back(8'h30);
            rxQ.push_back(8'h30);
            rxQ.push_back(`APL_ETX);
        end
        rdValid <= 1'b0;
        rdLast <= 1'b0;
        waitHi(doneAny);
        waitHi(idle);
    endtask
    initial begin
        seed = 96;
        errorCnt = 0;
        nTests = 0;
        {rst_n, start, isRead, execOk, execFail, execIsRead, rdValid, rdLast} = 8'h00;
        bodyLen = 8'h00;
        rdByte = 8'h00;
        bodyIdx = 8'h00;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        session(1'b0, 1'b1, 10, 0);
        session(1'b0, 1'b1, 4, 0);
        session(1'b0, 1'b0, 8, 0);
        session(1'b1, 1'b1, 4, 5);
        session(1'b1, 1'b0, 6, 0);
        for (k = 0; k < 6; k++) begin
            b = 8'($random(seed));
            session(b[0], b[1], 4 + b[5:2] % 13, b[0] & b[1] ? 1 + b[7:6] : 0);
        end
        giveVerdict();
    end
endmodule
